// file: core/irr_core.sv
// infrared remote receiver: filter, four-protocol decoder, registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: two-bit field picks 9012, NEC, RC5, RC6
// RQ2: customer mismatch flag, write-1 or auto clear
// RQ3: key mismatch flag, write-1 or auto clear
// RQ4: repeat flag cleared only by write-1
// RQ5: irq pending cleared only by write-1
// RQ6: interrupt only when all codes correct; a wake on a differing key also raises it, even with bad codes
// RQ7: no interrupt for repeats after bad frame
// RQ8: protocol error flag, write-1 or good-frame clear
// RQ9: customer compare width depends on protocol
// RQ10: key data layout depends on protocol
// RQ11: key register skips repeat codes
// RQ12: wake request and interrupt on key differing
// RQ13: wake key width depends on protocol
// RQ14: last customer code readable, per-mode layout
// RQ15: filter enable suppresses narrow pulses
// RQ16: filter width in low-speed clock cycles
// RQ17: 9012 frame: 8-unit leader, pulse distance
// RQ18: NEC frame: 16-unit leader, 8-unit space
// RQ19: RC5 frame: 14 Manchester bits, MSB first
// RQ20: RC6 mode 0 only, leader and trailer
// RQ21: receiver enable and interrupt enable gate
// RQ22: decoding paced by low-speed clock
module irr_core #(
  parameter int LEN_W = 9
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic lsclk_in,
  input wire logic ir_rx_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  output logic irq_out,
  output logic wake_req_out
);
  // segment counter must hold the longest leader and the timeout
  if (LEN_W < 9 || LEN_W > 16) begin : g_bad_len
    $error("LEN_W must lie between 9 and 16");
  end

  // rounds a segment length to whole protocol units
  function automatic logic [4:0] seg_units(input logic [LEN_W-1:0] len,
                                           input logic [LEN_W-1:0] unit);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 1; k < 32; k++) begin
      if (18'({len, 1'b0}) >= 18'(2 * k - 1) * 18'(unit)) begin
        n = 5'(k);
      end
    end
    return n;
  endfunction

  // one-cycle write decode
  function automatic logic wr_at(input logic [7:0] off);
    return wr_in && (addr_in == off);
  endfunction

  // ----------------------------------------------------------------
  // decoder state
  // ----------------------------------------------------------------
  irr_pkg::irr_state_t st_q, st_d;
  logic ls_q, ls_d;
  logic raw_q, raw_d;
  logic filt_q, filt_d;
  logic [2:0] fcnt_q, fcnt_d;
  logic [LEN_W-1:0] len_q, len_d;
  logic [47:0] sr_q, sr_d;
  logic [5:0] cnt_q, cnt_d;
  logic rep_q, rep_d;
  logic tick, seg, eof, perr, pd, bit_v, ok;
  logic [4:0] u;
  logic [LEN_W-1:0] unit, to_len;
  logic [3:0] ctl_q, ctl_d;
  logic [3:0] flt_q, flt_d;
  logic [1:0] ps;

  assign ps = ctl_q[1:0];
  assign pd = (ps == irr_pkg::PS_9012) || (ps == irr_pkg::PS_NEC);

  // next values of filter, segment timer and frame collector
  always_comb begin
    ls_d = lsclk_in;
    raw_d = ~ir_rx_n_in;
    tick = lsclk_in & ~ls_q;                             // [RQ22]
    st_d = st_q;
    filt_d = filt_q;
    fcnt_d = fcnt_q;
    len_d = len_q;
    sr_d = sr_q;
    cnt_d = cnt_q;
    rep_d = rep_q;
    seg = 1'b0;
    eof = 1'b0;
    perr = 1'b0;
    bit_v = 1'b0;
    ok = 1'b0;
    // protocol unit selects the timing grid of the decoder
    case (ps)                                            // [RQ1]
      irr_pkg::PS_RC5: unit = LEN_W'(irr_pkg::RC5_TK);
      irr_pkg::PS_RC6: unit = LEN_W'(irr_pkg::RC6_TK);
      default: unit = LEN_W'(irr_pkg::TM_TK);
    endcase
    to_len = pd ? LEN_W'(irr_pkg::TM_TK * irr_pkg::PD_TO_U)
                : LEN_W'(32'(unit) * irr_pkg::MAN_TO_U);
    u = seg_units(len_q, unit);
    if (tick) begin
      // a level must persist past the width before it is believed
      if (!flt_q[irr_pkg::FLT_EN] || raw_q == filt_q) begin // [RQ15]
        filt_d = raw_q;
        fcnt_d = 3'h0;
      end else if (fcnt_q >= flt_q[2:0]) begin           // [RQ16]
        filt_d = raw_q;
        fcnt_d = 3'h0;
      end else begin
        fcnt_d = fcnt_q + 3'h1;
      end
      if (filt_d != filt_q) begin
        seg = 1'b1;
        len_d = LEN_W'(1);
      end else if (len_q != '1) begin
        len_d = len_q + LEN_W'(1);
      end
    end
    if (!ctl_q[irr_pkg::CTL_EN]) begin                   // [RQ21]
      st_d = irr_pkg::S_IDLE;
    end else if (seg) begin
      case (st_q)
        irr_pkg::S_IDLE: begin
          // a space ended, so a mark starts a frame
          if (!filt_q) begin
            sr_d = 48'h0;
            cnt_d = 6'h0;
            st_d = (ps == irr_pkg::PS_RC5) ? irr_pkg::S_BODY
                                           : irr_pkg::S_LEAD;
          end
        end
        irr_pkg::S_LEAD: begin
          case (ps)
            irr_pkg::PS_9012: ok = (u >= 5'(irr_pkg::LEAD_9012_U - 1)) &&
                                   (u <= 5'(irr_pkg::LEAD_9012_U + 1));
            irr_pkg::PS_NEC: ok = (u >= 5'(irr_pkg::LEAD_NEC_U - 1)) &&
                                  (u <= 5'(irr_pkg::LEAD_NEC_U + 1));
            default: ok = (u == 5'(irr_pkg::RC6_LEAD_U));  // [RQ20]
          endcase
          st_d = ok ? irr_pkg::S_LGAP : irr_pkg::S_SKIP; // [RQ17] [RQ18]
          perr = ~ok;
        end
        irr_pkg::S_LGAP: begin
          rep_d = 1'b0;
          st_d = irr_pkg::S_BODY;
          if (pd && u == 5'(irr_pkg::GAP_U)) begin
            ok = 1'b1;
          end else if (ps == irr_pkg::PS_NEC &&
                       u == 5'(irr_pkg::NEC_REP_GAP_U)) begin
            rep_d = 1'b1;                                // [RQ18]
          end else if (ps == irr_pkg::PS_RC6 &&
                       u == 5'(irr_pkg::RC6_GAP_U)) begin
            ok = 1'b1;
          end else begin
            perr = 1'b1;
            st_d = irr_pkg::S_SKIP;
          end
        end
        irr_pkg::S_BODY: begin
          if (pd) begin
            // pulse distance: one-unit marks, space length is the bit
            bit_v = (u == 5'(irr_pkg::ONE_SPACE_U));     // [RQ17]
            if (filt_q) begin
              ok = (u == 5'h01);
            end else begin
              ok = (u == 5'h01 || bit_v) && !rep_q &&
                   (cnt_q < 6'(irr_pkg::PD_BITS));
              sr_d[31:0] = {bit_v, sr_q[31:1]};
              cnt_d = cnt_q + 6'h01;
            end
          end else begin
            // manchester: push one sample per half-bit unit
            ok = (u != 5'h00) &&
                 (u <= ((ps == irr_pkg::PS_RC5) ? 5'h02 : 5'h03)) &&
                 (7'(cnt_q) + 7'(u) <= ((ps == irr_pkg::PS_RC5) ?
                  7'(irr_pkg::RC5_UNITS) : 7'(irr_pkg::RC6_UNITS)));
            for (int k = 0; k < 3; k++) begin
              if (5'(k) < u) begin
                sr_d = {sr_d[46:0], filt_q};             // [RQ19]
              end
            end
            cnt_d = cnt_q + 6'(u);
          end
          if (!ok) begin
            perr = 1'b1;
            st_d = irr_pkg::S_SKIP;
          end
        end
        default: st_d = st_q;
      endcase
    end else if (tick && !filt_q && len_q == to_len &&
                 st_q != irr_pkg::S_IDLE) begin
      // a long space closes the frame; a broken frame is dropped
      eof = (st_q == irr_pkg::S_BODY);
      perr = (st_q == irr_pkg::S_LEAD) || (st_q == irr_pkg::S_LGAP);
      st_d = irr_pkg::S_IDLE;
    end
  end

  // decoder registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= irr_pkg::S_IDLE;
      ls_q <= 1'b0;
      raw_q <= 1'b0;
      filt_q <= 1'b0;
      fcnt_q <= 3'h0;
      len_q <= '0;
      sr_q <= 48'h0;
      cnt_q <= 6'h0;
      rep_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ls_q <= ls_d;
      raw_q <= raw_d;
      filt_q <= filt_d;
      fcnt_q <= fcnt_d;
      len_q <= len_d;
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      rep_q <= rep_d;
    end
  end

  // ----------------------------------------------------------------
  // frame evaluation
  // ----------------------------------------------------------------
  logic [47:0] f;
  logic fr_ok, fr_rep, tgl, cust_ok, key_ok, len_ok;
  logic [15:0] cu, ky, cmsk, kmsk;
  logic tgl_q, tgl_d, have_q, have_d;
  logic [15:0] cc_q, cc_d, wk_q, wk_d;

  // trailing spaces never make an edge, so they are padded here
  always_comb begin
    f = sr_q << (((ps == irr_pkg::PS_RC5) ? 6'(irr_pkg::RC5_UNITS)
                  : 6'(irr_pkg::RC6_UNITS)) - cnt_q);
    len_ok = (ps == irr_pkg::PS_RC5) ?
             (cnt_q + 6'h01 >= 6'(irr_pkg::RC5_UNITS)) :
             (cnt_q + 6'h01 >= 6'(irr_pkg::RC6_UNITS));
    cu = 16'h0000;
    ky = 16'h0000;
    tgl = 1'b0;
    key_ok = 1'b1;
    fr_rep = 1'b0;
    case (ps)
      irr_pkg::PS_RC5: begin
        fr_ok = len_ok;
        for (int j = 1; j < 14; j++) begin
          if (f[27-2*j] == f[26-2*j]) fr_ok = 1'b0;
        end
        tgl = f[22];
        for (int i = 0; i < 5; i++) cu[4-i] = f[20-2*i];
        for (int i = 0; i < 6; i++) ky[5-i] = f[10-2*i];
        cmsk = irr_pkg::MSK_RC5_CUST;
        kmsk = irr_pkg::MSK_RC5_KEY;
      end
      irr_pkg::PS_RC6: begin
        // start 1, mode bits 000, double-width trailer
        fr_ok = len_ok && f[43] && !f[42];               // [RQ20]
        for (int j = 1; j < 4; j++) begin
          if (f[43-2*j] || !f[42-2*j]) fr_ok = 1'b0;
        end
        if (f[35] != f[34] || f[33] != f[32] || f[35] == f[33]) begin
          fr_ok = 1'b0;
        end
        for (int i = 0; i < 16; i++) begin
          if (f[31-2*i] == f[30-2*i]) fr_ok = 1'b0;
        end
        tgl = f[35];
        for (int i = 0; i < 8; i++) begin
          cu[7-i] = f[31-2*i];
          ky[7-i] = f[15-2*i];
        end
        cmsk = irr_pkg::MSK_RC6;
        kmsk = irr_pkg::MSK_RC6;
      end
      default: begin
        fr_rep = (cnt_q != 6'(irr_pkg::PD_BITS));
        fr_ok = (cnt_q == 6'(irr_pkg::PD_BITS) && !rep_q) ||
                (ps == irr_pkg::PS_9012 && cnt_q == 6'h01 && sr_q[31]) ||
                (ps == irr_pkg::PS_NEC && rep_q && cnt_q == 6'h00);
        cu = sr_q[15:0];
        ky = sr_q[31:16];
        key_ok = (ky[15:8] == ~ky[7:0]);                 // [RQ3]
        cmsk = irr_pkg::MSK_PD;
        kmsk = irr_pkg::MSK_PD;
      end
    endcase
    // unchanged toggle after any decoded data frame marks a held key
    if (!pd) fr_rep = have_q && (tgl == tgl_q);
    cust_ok = ((cu ^ cc_q) & cmsk) == 16'h0000;          // [RQ9]
  end

  // ----------------------------------------------------------------
  // register file and status
  // ----------------------------------------------------------------
  logic cm_q, cm_d, km_q, km_d, rp_q, rp_d, ip_q, ip_d, pe_q, pe_d;
  logic lg_q, lg_d, wake_q, wake_d;
  logic [15:0] kdc_q, kdc_d, rcc_q, rcc_d, w1c, st_word;
  logic [31:0] rdat_q, rdat_d;
  logic ev_data, ev_rep, bad, good, wake;

  // hardware sets win over software write-1 clears
  always_comb begin
    ctl_d = wr_at(irr_pkg::OFF_CTL) ? wr_data_in[3:0] : ctl_q;
    flt_d = wr_at(irr_pkg::OFF_FLT) ? wr_data_in[3:0] : flt_q;
    cc_d = wr_at(irr_pkg::OFF_CC) ? wr_data_in[15:0] : cc_q;
    wk_d = wr_at(irr_pkg::OFF_WK) ? wr_data_in[15:0] : wk_q;
    w1c = wr_at(irr_pkg::OFF_STAT) ? wr_data_in[15:0] : 16'h0000;
    ev_data = eof & fr_ok & ~fr_rep;
    ev_rep = eof & fr_ok & fr_rep;
    bad = perr | (eof & ~fr_ok);
    good = ev_data & cust_ok & key_ok;                   // [RQ6]
    wake = ev_data && ((ky ^ wk_q) & kmsk) != 16'h0000;  // [RQ12] [RQ13]
    cm_d = (cm_q & ~w1c[irr_pkg::ST_CUST] & ~(ev_data & cust_ok)) |
           (ev_data & ~cust_ok);                         // [RQ2]
    km_d = (km_q & ~w1c[irr_pkg::ST_KEY] & ~(ev_data & key_ok)) |
           (ev_data & ~key_ok);                          // [RQ3]
    rp_d = (rp_q & ~w1c[irr_pkg::ST_REP]) | ev_rep;      // [RQ4]
    ip_d = (ip_q & ~w1c[irr_pkg::ST_IRQ]) | good |
           (ev_rep & lg_q) | wake;                       // [RQ5] [RQ7]
    pe_d = (pe_q & ~w1c[irr_pkg::ST_ERR] & ~good) | bad; // [RQ8]
    lg_d = ev_data ? good : (bad ? 1'b0 : lg_q);
    tgl_d = ev_data ? tgl : tgl_q;
    have_d = ev_data ? 1'b1 : (ctl_q[irr_pkg::CTL_EN] ? have_q : 1'b0);
    // repeats leave the key and customer registers alone
    kdc_d = wr_at(irr_pkg::OFF_KDC) ? wr_data_in[15:0] : kdc_q;
    if (ev_data) kdc_d = ky & kmsk;                      // [RQ10] [RQ11]
    rcc_d = ev_data ? (cu & cmsk) : rcc_q;               // [RQ14]
    wake_d = wake;
    st_word = 16'h0000;
    st_word[irr_pkg::ST_CUST] = cm_q;
    st_word[irr_pkg::ST_KEY] = km_q;
    st_word[irr_pkg::ST_REP] = rp_q;
    st_word[irr_pkg::ST_IRQ] = ip_q;
    st_word[irr_pkg::ST_ERR] = pe_q;
    rdat_d = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        irr_pkg::OFF_CTL: rdat_d = {28'h0, ctl_q};
        irr_pkg::OFF_STAT: rdat_d = {16'h0, st_word};
        irr_pkg::OFF_CC: rdat_d = {16'h0, cc_q};
        irr_pkg::OFF_KDC: rdat_d = {16'h0, kdc_q};
        irr_pkg::OFF_WK: rdat_d = {16'h0, wk_q};
        irr_pkg::OFF_RCC: rdat_d = {16'h0, rcc_q};
        irr_pkg::OFF_FLT: rdat_d = {28'h0, flt_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl_q <= irr_pkg::NIB_RST;
      flt_q <= irr_pkg::NIB_RST;
      cc_q <= irr_pkg::REG_RST;
      wk_q <= irr_pkg::REG_RST;
      kdc_q <= irr_pkg::REG_RST;
      rcc_q <= irr_pkg::REG_RST;
      cm_q <= 1'b0;
      km_q <= 1'b0;
      rp_q <= 1'b0;
      ip_q <= 1'b0;
      pe_q <= 1'b0;
      lg_q <= 1'b0;
      tgl_q <= 1'b0;
      have_q <= 1'b0;
      wake_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ctl_q <= ctl_d;
      flt_q <= flt_d;
      cc_q <= cc_d;
      wk_q <= wk_d;
      kdc_q <= kdc_d;
      rcc_q <= rcc_d;
      cm_q <= cm_d;
      km_q <= km_d;
      rp_q <= rp_d;
      ip_q <= ip_d;
      pe_q <= pe_d;
      lg_q <= lg_d;
      tgl_q <= tgl_d;
      have_q <= have_d;
      wake_q <= wake_d;
      rdat_q <= rdat_d;
    end
  end

  // status keeps recording while the interrupt line is gated off
  assign irq_out = ip_q & ctl_q[irr_pkg::CTL_IE];        // [RQ21]
  assign wake_req_out = wake_q;
  assign rd_data_out = rdat_q;
endmodule
`default_nettype wire

// file: common/irr_pkg.sv
// constants, register map and state type of the infrared remote receiver
package irr_pkg;
  // ----------------------------------------------------------------
  // register bus and map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CTL = 8'h80;
  localparam logic [7:0] OFF_STAT = 8'h81;
  localparam logic [7:0] OFF_CC = 8'h82;
  localparam logic [7:0] OFF_KDC = 8'h83;
  localparam logic [7:0] OFF_WK = 8'h84;
  localparam logic [7:0] OFF_RCC = 8'h85;
  localparam logic [7:0] OFF_FLT = 8'h86;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [3:0] NIB_RST = 4'h0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN = 3;
  localparam int CTL_IE = 2;
  localparam int ST_CUST = 6;
  localparam int ST_KEY = 5;
  localparam int ST_REP = 4;
  localparam int ST_IRQ = 2;
  localparam int ST_ERR = 0;
  localparam int FLT_EN = 3;
  localparam int FLT_W_W = 3;
  // ----------------------------------------------------------------
  // protocol select codes and code masks
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_9012 = 2'h0;
  localparam logic [1:0] PS_NEC = 2'h1;
  localparam logic [1:0] PS_RC5 = 2'h2;
  localparam logic [1:0] PS_RC6 = 2'h3;
  localparam logic [15:0] MSK_RC5_CUST = 16'h001f;
  localparam logic [15:0] MSK_RC5_KEY = 16'h003f;
  localparam logic [15:0] MSK_RC6 = 16'h00ff;
  localparam logic [15:0] MSK_PD = 16'hffff;
  // ----------------------------------------------------------------
  // timing: low-speed clock period and protocol units, in ns and in ticks
  // ----------------------------------------------------------------
  localparam int LS_PERIOD_NS = 30517;
  localparam int TM_NS = 560000;
  localparam int RC5_HALF_NS = 844000;
  localparam int RC6_T_NS = 444000;
  localparam int TM_TK = TM_NS / LS_PERIOD_NS;
  localparam int RC5_TK = RC5_HALF_NS / LS_PERIOD_NS;
  localparam int RC6_TK = RC6_T_NS / LS_PERIOD_NS;
  // segment lengths counted in protocol units
  localparam int LEAD_9012_U = 8;
  localparam int LEAD_NEC_U = 16;
  localparam int GAP_U = 8;
  localparam int NEC_REP_GAP_U = 4;
  localparam int ONE_SPACE_U = 3;
  localparam int RC6_LEAD_U = 6;
  localparam int RC6_GAP_U = 2;
  localparam int PD_BITS = 32;
  localparam int RC5_UNITS = 27;
  localparam int RC6_UNITS = 44;
  localparam int PD_TO_U = 12;
  localparam int MAN_TO_U = 6;
  // ----------------------------------------------------------------
  // decoder states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_LEAD, S_LGAP, S_BODY, S_SKIP
  } irr_state_t;
endpackage

// file: tb/irr_ir_tx.sv
// behavioural infrared receiver module driving the decoder input
`timescale 1ns/1ps
`default_nettype none
module irr_ir_tx (
  input wire logic clk_in,
  output logic lsclk_out,
  output logic ir_n_out
);
  // ---------------------------------------------------------------
  // low-speed clock and idle line
  // ---------------------------------------------------------------
  // the slow clock is scaled to two system cycles a period so that
  // whole frames fit in a short run; the decoder only counts ticks
  initial begin
    lsclk_out = 1'b0;
    ir_n_out = 1'b1;
  end
  always @(posedge clk_in) begin
    lsclk_out <= ~lsclk_out;
  end
  // ---------------------------------------------------------------
  // frame shaping
  // ---------------------------------------------------------------
  // hold one line level for a number of slow ticks; low means mark
  task automatic seg(input logic lvl, input int ticks);
    ir_n_out <= lvl;
    repeat (ticks) @(posedge lsclk_out);
  endtask
  // pulse-distance frame: leader, gap, lsb-first bits, stop mark
  task automatic send_pd(input int lead, input int gap, input int nbits,
                         input logic [31:0] data);
    int u;
    u = irr_pkg::TM_TK;
    @(posedge lsclk_out);
    seg(1'b0, lead * u);
    seg(1'b1, gap * u);
    for (int i = 0; i < nbits; i++) begin
      seg(1'b0, u);
      seg(1'b1, (data[i] ? 3 : 1) * u);
    end
    seg(1'b0, u);
    seg(1'b1, 13 * u); // line released, idles high
  endtask
  // manchester frame, msb first: a one is space then mark
  task automatic send_rc5(input logic [13:0] bits);
    @(posedge lsclk_out);
    for (int i = 13; i >= 0; i--) begin
      seg(bits[i], irr_pkg::RC5_TK);
      seg(~bits[i], irr_pkg::RC5_TK);
    end
    seg(1'b1, 7 * irr_pkg::RC5_TK);
  endtask
  // rc6 mode 0 after its leader: a one is mark then space
  task automatic send_rc6(input logic [20:0] bits);
    @(posedge lsclk_out);
    seg(1'b0, 6 * irr_pkg::RC6_TK);
    seg(1'b1, 2 * irr_pkg::RC6_TK);
    for (int i = 20; i >= 0; i--) begin
      seg(~bits[i], (i == 16 ? 2 : 1) * irr_pkg::RC6_TK);
      seg(bits[i], (i == 16 ? 2 : 1) * irr_pkg::RC6_TK);
    end
    seg(1'b1, 8 * irr_pkg::RC6_TK);
  endtask
endmodule
`default_nettype wire

// file: tb/irr_core_assertions.sv
// port-level checker for the infrared remote receiver
`timescale 1ns/1ps
`default_nettype none
module irr_core_assertions #(
  parameter int LEN_W = 9
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic lsclk_in,
  input wire logic ir_rx_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic irq_out,
  input wire logic wake_req_out
);
  // ---------------------------------------------------------------
  // register readback, interrupt and wake request relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ctl_readback: assert property (wr_in && addr_in == irr_pkg::OFF_CTL ##2
    rd_in && addr_in == irr_pkg::OFF_CTL |=> rd_data_out ==
    {28'h0, $past(wr_data_in[3:0], 3)}) else $error("control readback");
  a_cc_readback: assert property (wr_in && addr_in == irr_pkg::OFF_CC ##2
    rd_in && addr_in == irr_pkg::OFF_CC |=> rd_data_out ==
    {16'h0, $past(wr_data_in[15:0], 3)}) else $error("customer readback");
  a_wk_readback: assert property (wr_in && addr_in == irr_pkg::OFF_WK ##2
    rd_in && addr_in == irr_pkg::OFF_WK |=> rd_data_out ==
    {16'h0, $past(wr_data_in[15:0], 3)}) else $error("wake key readback");
  a_flt_readback: assert property (wr_in && addr_in == irr_pkg::OFF_FLT ##2
    rd_in && addr_in == irr_pkg::OFF_FLT |=> rd_data_out ==
    {28'h0, $past(wr_data_in[3:0], 3)}) else $error("filter readback");
  a_stat_reserved: assert property (rd_in && addr_in == irr_pkg::OFF_STAT
    |=> rd_data_out[31:7] == 25'h0 && !rd_data_out[3] && !rd_data_out[1])
    else $error("status reserved bits set");
  a_irq_masked: assert property (wr_in && addr_in == irr_pkg::OFF_CTL &&
    !wr_data_in[2] |=> !irq_out) else $error("irq not masked");
  a_irq_fall: assert property ($fell(irq_out) |-> $past(wr_in))
    else $error("irq dropped without a write");
  a_wake_pulse: assert property (wake_req_out |=> !wake_req_out)
    else $error("wake request longer than one cycle");
  a_wake_tick: assert property (wake_req_out |-> $past(lsclk_in) ||
    $past(lsclk_in, 2) || $past(lsclk_in, 3)) else $error("wake off tick");
  // main scenarios reached
  c_wake: cover property (wake_req_out);
  c_irq: cover property ($rose(irq_out));
  c_stat: cover property (rd_in && addr_in == irr_pkg::OFF_STAT);
endmodule
bind irr_core irr_core_assertions #(.LEN_W(LEN_W)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .lsclk_in(lsclk_in),
  .ir_rx_n_in(ir_rx_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .irq_out(irq_out), .wake_req_out(wake_req_out));
`default_nettype wire

// file: tb/irr_core_test.sv
// self-checking bench for the infrared remote receiver
`timescale 1ns/1ps
`default_nettype none
module irr_core_test;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  wire lsclk_in;
  wire ir_rx_n_in;
  logic [31:0] rd_data_out;
  logic irq_out;
  logic wake_req_out;
  int err_count = 0;
  int check_count = 0;
  int wake_n = 0;
  // ---------------------------------------------------------------
  // design, far side and clock
  // ---------------------------------------------------------------
  irr_core #(.LEN_W(9)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .lsclk_in(lsclk_in), .ir_rx_n_in(ir_rx_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out),
    .wake_req_out(wake_req_out));
  irr_ir_tx i_tx (.clk_in(clk_in), .lsclk_out(lsclk_in),
    .ir_n_out(ir_rx_n_in));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // count wake pulses; each judged frame expects an exact number
  always @(posedge clk_in) begin
    if (wake_req_out === 1'b1) wake_n <= wake_n + 1;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp, input string s);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rd_data_out, exp, s);
  endtask
  // judge a finished frame: status, key, customer and wake count
  task after(input logic [31:0] st, input logic [31:0] key,
             input logic [31:0] cc, input int wk);
    repeat (8) @(posedge clk_in);
    rd(irr_pkg::OFF_STAT, st, "status");
    rd(irr_pkg::OFF_KDC, key, "key data");
    rd(irr_pkg::OFF_RCC, cc, "customer");
    chk(32'(wake_n), 32'(wk), "wake count");
    wake_n = 0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    for (int i = 0; i < 8; i++) rd(8'(128 + i), 32'h0, "reset value");
    wr(irr_pkg::OFF_CTL, 32'hff);
    rd(irr_pkg::OFF_CTL, 32'hf, "control");
    wr(irr_pkg::OFF_FLT, 32'hffffffff);
    rd(irr_pkg::OFF_FLT, 32'hf, "filter");
    wr(irr_pkg::OFF_FLT, 32'h0);
    wr(irr_pkg::OFF_CC, 32'h5a3c);
    rd(irr_pkg::OFF_CC, 32'h5a3c, "expected customer");
    wr(irr_pkg::OFF_WK, 32'hde21);
    rd(irr_pkg::OFF_WK, 32'hde21, "wake key");
    wr(irr_pkg::OFF_RCC, 32'hffff);
    rd(irr_pkg::OFF_RCC, 32'h0, "read-only");
    wr(8'h90, 32'hffff);
    rd(8'h90, 32'h0, "unmapped");
  endtask
  task t_nec;
    wr(irr_pkg::OFF_CTL, 32'hd);
    i_tx.send_pd(16, 8, 32, 32'hde215a3c);
    after(32'h4, 32'hde21, 32'h5a3c, 0);
    chk({31'h0, irq_out}, 32'h1, "irq raised");
    wr(irr_pkg::OFF_STAT, 32'h75);
    #1 chk({31'h0, irq_out}, 32'h0, "irq cleared");
    i_tx.send_pd(16, 4, 0, 32'h0);
    after(32'h14, 32'hde21, 32'h5a3c, 0);
    wr(irr_pkg::OFF_STAT, 32'h75);
    i_tx.send_pd(16, 8, 32, 32'hde215a3d);
    after(32'h40, 32'hde21, 32'h5a3d, 0);
    i_tx.send_pd(16, 4, 0, 32'h0);
    after(32'h50, 32'hde21, 32'h5a3d, 0);
    i_tx.send_pd(10, 8, 32, 32'hde215a3c);
    after(32'h51, 32'hde21, 32'h5a3d, 0);
    i_tx.send_pd(16, 8, 32, 32'hde215a3c);
    after(32'h14, 32'hde21, 32'h5a3c, 0);
    wr(irr_pkg::OFF_STAT, 32'h75);
    i_tx.send_pd(16, 8, 32, 32'h00215a3c);
    after(32'h24, 32'h0021, 32'h5a3c, 1);
  endtask
  task t_9012;
    wr(irr_pkg::OFF_STAT, 32'h75);
    wr(irr_pkg::OFF_CTL, 32'hc);
    wr(irr_pkg::OFF_FLT, 32'hf);
    i_tx.seg(1'b0, 3);
    i_tx.seg(1'b1, 250);
    i_tx.send_pd(8, 8, 32, 32'hed125a3c);
    after(32'h4, 32'hed12, 32'h5a3c, 1);
    i_tx.send_pd(8, 8, 1, 32'h1);
    after(32'h14, 32'hed12, 32'h5a3c, 0);
  endtask
  // status still records with the interrupt masked; nothing when off
  task t_off;
    wr(irr_pkg::OFF_STAT, 32'h75);
    wr(irr_pkg::OFF_CTL, 32'h8);
    i_tx.send_pd(8, 8, 32, 32'hed125a3c);
    after(32'h4, 32'hed12, 32'h5a3c, 1);
    chk({31'h0, irq_out}, 32'h0, "irq masked");
    wr(irr_pkg::OFF_CTL, 32'h0);
    i_tx.send_pd(8, 8, 32, 32'hde215a3d);
    after(32'h4, 32'hed12, 32'h5a3c, 0);
  endtask
  task t_rc5;
    wr(irr_pkg::OFF_STAT, 32'h75);
    wr(irr_pkg::OFF_CC, 32'h15);
    wr(irr_pkg::OFF_CTL, 32'he);
    i_tx.send_rc5({2'b11, 1'b0, 5'h15, 6'h2a});
    after(32'h4, 32'h2a, 32'h15, 1);
    i_tx.send_rc5({2'b11, 1'b0, 5'h15, 6'h2a});
    after(32'h14, 32'h2a, 32'h15, 0);
  endtask
  task t_rc6;
    wr(irr_pkg::OFF_STAT, 32'h75);
    wr(irr_pkg::OFF_CC, 32'ha5);
    wr(irr_pkg::OFF_CTL, 32'hf);
    i_tx.send_rc6({4'h8, 1'b1, 16'ha53c});
    after(32'h4, 32'h3c, 32'ha5, 1);
    i_tx.send_rc6({4'h8, 1'b1, 16'ha53c});
    after(32'h14, 32'h3c, 32'ha5, 0);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_nec;
    t_9012;
    t_off;
    t_rc5;
    t_rc6;
    end_sim;
  end
  // the whole run needs about 200 us; twice that means a hang
  initial begin
    #400us;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule
`default_nettype wire
